// ---- design/pin_ctrl_pkg.sv ----
package pin_ctrl_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  // Least time for the graceful stop or restart of output switching
  localparam int unsigned RAMP_TIME_NS  = 1000;
  localparam int unsigned RAMP_CYCLES   = (RAMP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Pin codes and decoded settings
  // ---------------------------------------------------------------
  localparam logic [1:0] GAIN_CODE_19P2 = 2'h0;
  localparam logic [1:0] GAIN_CODE_22P6 = 2'h1;
  localparam logic [1:0] GAIN_CODE_25   = 2'h2;
  localparam logic [1:0] GAIN_CODE_SW   = 2'h3;
  // Analog gain step driven to the modulator
  localparam logic [1:0] AGAIN_19P2     = 2'h0;
  localparam logic [1:0] AGAIN_22P6     = 2'h1;
  localparam logic [1:0] AGAIN_25       = 2'h2;
  // Digital boost code for +6 dB
  localparam logic [1:0] BOOST_6DB      = 2'h1;
  // Volume code meaning 0 dB
  localparam logic [7:0] VOLUME_0DB     = 8'hcf;
  // Output switching rate as a multiple of the sample rate
  localparam logic [4:0] RATE_MULT_16   = 5'h10;
  localparam logic [4:0] RATE_MULT_8    = 5'h08;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    STAGE_RUN,
    STAGE_STOPPING,
    STAGE_HIZ,
    STAGE_STARTING
  } stage_e;

  typedef struct packed {
    logic       sleep_addr;
    logic [1:0] gain;
    logic       bridge_clk;
    logic       rate_data;
  } pin_bus_s;

  typedef struct packed {
    logic [1:0] analog_gain;
    logic [1:0] boost;
    logic [7:0] volume;
    logic       bridge_mode;
    logic [4:0] rate_mult;
    logic       mute;
    logic       sleep;
  } sw_config_s;

  typedef struct packed {
    logic [1:0] analog_gain;
    logic [1:0] boost;
    logic [7:0] volume;
    logic       bridge_mode;
    logic [4:0] rate_mult;
  } amp_config_s;

endpackage : pin_ctrl_pkg

// ---- design/pin_sync.sv ----
`timescale 1ns/10ps

// Three-stage synchroniser; a change is taken once stages two and three agree
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // Pins and clean copy
  input  wire logic [WIDTH-1:0] raw,
  output logic      [WIDTH-1:0] clean
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] clean;
  } sync_s;

  sync_s st;
  sync_s next_st;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Stage one feeds stage two only; agreement filters a late settle
  always_comb begin
    next_st    = st;
    next_st.s1 = raw;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.clean[i] = st.s3[i];
      end
    end
  end

  // Register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign clean = st.clean;

endmodule : pin_sync

// ---- design/hw_mode_pin_control_decode.sv ----
`timescale 1ns/10ps

module hw_mode_pin_control_decode
  import pin_ctrl_pkg::*;
#(
  parameter int unsigned RAMP_LEN = RAMP_CYCLES
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // Device pins
  input  wire logic        sleep_addr_select_pin,
  input  wire logic [1:0]  gain_select_pins,
  input  wire logic        bridge_mode_clock_pin,
  input  wire logic        switch_rate_data_pin_in,
  output logic             switch_rate_data_pin_out,
  output logic             switch_rate_data_pin_oe,
  // Control register values and serial port drive request
  input  wire sw_config_s  sw_cfg,
  input  wire logic        i2c_sda_drive_low,
  // Serial control port view of the pins
  output logic             i2c_scl,
  output logic             i2c_sda,
  output logic             i2c_addr_select,
  // Amplifier settings and status
  output logic             software_mode,
  output amp_config_s      amp_cfg,
  output logic             stage_switching,
  output logic             stage_hiz,
  output logic             mute_5050,
  output logic             ramp_active,
  output logic             signal_path_enable
);

  localparam int RAMP_N = int'(RAMP_LEN);

  // Counter must hold the ramp length
  if (RAMP_LEN < 1 || RAMP_LEN > 256) begin : g_bad_ramp
    $error("RAMP_LEN must lie between 1 and 256");
  end

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic [1:0] rst_pipe;
  logic       rst_n;

  // Asynchronous assert, release after two edges
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  pin_bus_s pins_raw;
  pin_bus_s pins;

  assign pins_raw = '{sleep_addr: sleep_addr_select_pin, gain: gain_select_pins,
                      bridge_clk: bridge_mode_clock_pin, rate_data: switch_rate_data_pin_in};

  pin_sync #(
    .WIDTH ($bits(pin_bus_s))
  ) u_pin_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .raw     (pins_raw),
    .clean   (pins)
  );

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic logic [1:0] analog_step(input logic [1:0] code);
    logic [1:0] step;
    step = AGAIN_19P2;
    unique case (code)
      GAIN_CODE_22P6: step = AGAIN_22P6;
      GAIN_CODE_25:   step = AGAIN_25;
      default:        step = AGAIN_19P2;
    endcase
    return step;
  endfunction : analog_step

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    stage_e      stage;
    logic [7:0]  ramp_cnt;
    logic        sw_mode;
    amp_config_s cfg;
    logic        switching;
    logic        hiz;
    logic        mute;
    logic        ramp;
    logic        path_en;
    logic        scl;
    logic        sda;
    logic        addr_sel;
    logic        sda_oe;
    logic        sda_out;
  } ctrl_s;

  ctrl_s st;
  ctrl_s next_st;
  logic  sw_sel;
  logic  sleep_req;

  // Mode and sleep source; the sleep pin doubles as address select in software mode
  // software mode entry
  assign sw_sel    = (pins.gain == GAIN_CODE_SW);
  assign sleep_req = sw_sel ? sw_cfg.sleep : pins.sleep_addr;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st         = st;
    next_st.sw_mode = sw_sel;
    if (sw_sel) begin
      next_st.cfg = '{analog_gain: sw_cfg.analog_gain, boost: sw_cfg.boost, volume: sw_cfg.volume,
                      bridge_mode: sw_cfg.bridge_mode, rate_mult: sw_cfg.rate_mult};
    end else begin
      next_st.cfg.analog_gain = analog_step(pins.gain);
      next_st.cfg.boost       = BOOST_6DB;
      next_st.cfg.volume      = VOLUME_0DB;
      next_st.cfg.bridge_mode = pins.bridge_clk;
      next_st.cfg.rate_mult   = pins.rate_data ? RATE_MULT_8 : RATE_MULT_16;
    end

    // pins become serial lines; idle high outside software mode
    next_st.scl      = sw_sel ? pins.bridge_clk : 1'b1;
    next_st.sda      = sw_sel ? pins.rate_data : 1'b1;
    next_st.addr_sel = sw_sel & pins.sleep_addr;
    // Open drain: only ever pulls low, and never while the pin is a strap
    next_st.sda_oe   = sw_sel & i2c_sda_drive_low;
    // Pin level when driven is always low; kept in a flop like every output
    next_st.sda_out  = 1'b0;

    // graceful stop sequence; a stop or restart always runs to its end
    unique case (st.stage)
      STAGE_RUN: begin
        if (sleep_req) begin
          next_st.stage    = STAGE_STOPPING;
          next_st.ramp_cnt = 8'(RAMP_LEN - 1);
        end
      end
      STAGE_STOPPING: begin
        if (st.ramp_cnt == 8'h00) begin
          next_st.stage = STAGE_HIZ;
        end else begin
          next_st.ramp_cnt = st.ramp_cnt - 8'h01;
        end
      end
      STAGE_HIZ: begin
        if (!sleep_req) begin
          next_st.stage    = STAGE_STARTING;
          next_st.ramp_cnt = 8'(RAMP_LEN - 1);
        end
      end
      STAGE_STARTING: begin
        if (st.ramp_cnt == 8'h00) begin
          next_st.stage = STAGE_RUN;
        end else begin
          next_st.ramp_cnt = st.ramp_cnt - 8'h01;
        end
      end
    endcase

    // Status follows the next stage so outputs stay flop-driven
    next_st.switching = (next_st.stage != STAGE_HIZ);
    next_st.hiz       = (next_st.stage == STAGE_HIZ);
    next_st.ramp      = (next_st.stage == STAGE_STOPPING) || (next_st.stage == STAGE_STARTING);
    next_st.mute      = sw_sel & sw_cfg.mute & (next_st.stage == STAGE_RUN);
    next_st.path_en   = 1'b1;
  end

  // Register; hardware-mode defaults after reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st           <= '0;
      st.stage     <= STAGE_RUN;
      st.cfg.boost <= BOOST_6DB;
      st.cfg.volume <= VOLUME_0DB;
      st.cfg.rate_mult <= RATE_MULT_16;
      st.switching <= 1'b1;
      st.scl       <= 1'b1;
      st.sda       <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign software_mode            = st.sw_mode;
  assign amp_cfg                  = st.cfg;
  assign stage_switching          = st.switching;
  assign stage_hiz                = st.hiz;
  assign mute_5050                = st.mute;
  assign ramp_active              = st.ramp;
  assign signal_path_enable       = st.path_en;
  assign i2c_scl                  = st.scl;
  assign i2c_sda                  = st.sda;
  assign i2c_addr_select          = st.addr_sel;
  assign switch_rate_data_pin_oe  = st.sda_oe;
  assign switch_rate_data_pin_out = st.sda_out;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_SLEEP_HIZ: assert property ($rose(st.stage == STAGE_STOPPING) |-> ##RAMP_N stage_hiz)
    else $error("Sleep did not reach high-Z after ramp");
  AST_PATH_AWAKE: assert property (stage_hiz |-> signal_path_enable)
    else $error("Signal path stopped during sleep");
  AST_MUTE_SWITCHING: assert property (mute_5050 |-> stage_switching && !stage_hiz && software_mode)
    else $error("Mute shown without switching");
  AST_GAIN_DECODE: assert property ((pins.gain == 2'h1) |=> amp_cfg.analog_gain == AGAIN_22P6
    && !software_mode) else $error("Gain code 01 not decoded");
  AST_HW_DIGITAL: assert property (!software_mode |-> amp_cfg.boost == BOOST_6DB
    && amp_cfg.volume == VOLUME_0DB) else $error("Digital gain moved in hardware mode");
  AST_SW_ENTRY: assert property ((pins.gain == 2'h3) |=> software_mode)
    else $error("Code 11 did not select software mode");
  AST_SCL_ROUTE: assert property (software_mode |-> i2c_scl == $past(pins.bridge_clk))
    else $error("Clock pin not routed to serial port");
  AST_RATE_STRAP: assert property ((pins.gain != 2'h3 && !pins.rate_data) |=> amp_cfg.rate_mult == 5'h10)
    else $error("Rate pin low did not give 16x");
  AST_BRIDGE_STRAP: assert property ((pins.gain == 2'h0 && pins.bridge_clk) |=> amp_cfg.bridge_mode)
    else $error("Bridge pin high did not select parallel mode");
  AST_SW_IGNORE: assert property (software_mode |-> amp_cfg.analog_gain == $past(sw_cfg.analog_gain))
    else $error("Software mode gain not from registers");

  COV_SLEEP: cover property ($rose(stage_hiz));
  COV_WAKE: cover property ($fell(stage_hiz) ##[1:300] (st.stage == STAGE_RUN));
  COV_SW_MODE: cover property ($rose(software_mode));

endmodule : hw_mode_pin_control_decode

// ---- tb/pin_host_model.sv ----
`timescale 1ns/10ps

// Board straps or host controller at the device pins
module pin_host_model
  import pin_ctrl_pkg::*;
(
  // Host side requests
  input  wire pin_bus_s want,
  input  wire logic     stop_audio,
  // Device drive of the shared data pin
  input  wire logic     sda_oe,
  input  wire logic     sda_out,
  // Pin levels and audio stream state
  output pin_bus_s      pins,
  output logic          audio_on
);
  // ---------------------------------------------------------------
  // Pin levels
  // ---------------------------------------------------------------
  // Data pin has a pull-up; the device can only pull it low
  always_comb begin
    pins           = want;
    pins.rate_data = want.rate_data & ~(sda_oe & ~sda_out);
  end

  // sleep before stop
  // Audio is only stopped while the sleep pin is already high, avoiding pops
  assign audio_on = ~(stop_audio & want.sleep_addr);
endmodule : pin_host_model

// ---- tb/hw_mode_pin_control_decode_bench.sv ----
`timescale 1ns/10ps

module hw_mode_pin_control_decode_bench;
  import pin_ctrl_pkg::*;
  localparam int unsigned RAMP = 4;

  logic        ref_clk, resetn, drive_low, stop_audio, pin_out, pin_oe, audio_on;
  logic        i2c_scl, i2c_sda, i2c_addr_select, software_mode, stage_switching;
  logic        stage_hiz, mute_5050, ramp_active, signal_path_enable;
  pin_bus_s    want, pins;
  sw_config_s  sw_cfg;
  amp_config_s amp_cfg, exp_cfg;
  int          num_errors, cmp_count, cycles;

  // ---------------------------------------------------------------
  // Clock, reset and instances
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  pin_host_model pin_host_model_inst (.want(want), .stop_audio(stop_audio), .sda_oe(pin_oe),
    .sda_out(pin_out), .pins(pins), .audio_on(audio_on));

  hw_mode_pin_control_decode #(.RAMP_LEN(RAMP)) hw_mode_pin_control_decode_inst (
    .ref_clk(ref_clk), .resetn(resetn), .sleep_addr_select_pin(pins.sleep_addr),
    .gain_select_pins(pins.gain), .bridge_mode_clock_pin(pins.bridge_clk),
    .switch_rate_data_pin_in(pins.rate_data), .switch_rate_data_pin_out(pin_out),
    .switch_rate_data_pin_oe(pin_oe), .sw_cfg(sw_cfg), .i2c_sda_drive_low(drive_low),
    .i2c_scl(i2c_scl), .i2c_sda(i2c_sda), .i2c_addr_select(i2c_addr_select),
    .software_mode(software_mode), .amp_cfg(amp_cfg), .stage_switching(stage_switching),
    .stage_hiz(stage_hiz), .mute_5050(mute_5050), .ramp_active(ramp_active),
    .signal_path_enable(signal_path_enable));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Pins take four edges through the synchroniser; eight leaves margin
  task automatic settle();
    repeat (8) @(posedge ref_clk);
    #1;
  endtask : settle

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  // Hang guard, far above the hundred or so cycles the tests need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      summarize();
    end
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Every hardware gain code, each with one setting of the two straps, register values set to decoys
  task automatic hw_decode();
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      want.gain       <= i[1:0];
      want.rate_data  <= i[0];
      want.bridge_clk <= i[1];
      settle();
      chk("analog_gain", (i == 0) ? AGAIN_19P2 : (i == 1) ? AGAIN_22P6 : AGAIN_25, amp_cfg.analog_gain);
      chk("boost", BOOST_6DB, amp_cfg.boost);
      chk("volume", VOLUME_0DB, amp_cfg.volume);
      chk("rate_mult", i[0] ? RATE_MULT_8 : RATE_MULT_16, amp_cfg.rate_mult);
      chk("bridge_mode", i[1], amp_cfg.bridge_mode);
      chk("software_mode", 1'b0, software_mode);
      chk("i2c_scl idle", 1'b1, i2c_scl);
    end
  endtask : hw_decode

  // Sleep request from the pin or from the register, then wake again
  task automatic sleep_cycle(input logic from_reg);
    int n;
    @(posedge ref_clk);
    if (from_reg) sw_cfg.sleep <= 1'b1;
    else want.sleep_addr <= 1'b1;
    n = 0;
    while (ramp_active !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("ramp start", 1'b1, ramp_active);
    n = 0;
    while (stage_hiz !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("ramp length", RAMP, n);
    chk("switching asleep", 1'b0, stage_switching);
    chk("mute asleep", 1'b0, mute_5050);
    chk("signal path", 1'b1, signal_path_enable);
    @(posedge ref_clk);
    stop_audio <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk("audio stopped", 1'b0, audio_on);
    chk("hiz audio off", 1'b1, stage_hiz);
    @(posedge ref_clk);
    stop_audio <= 1'b0;
    if (from_reg) sw_cfg.sleep <= 1'b0;
    else want.sleep_addr <= 1'b0;
    n = 0;
    while (stage_switching !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    // Switching resumes as the restart ramp begins; pins add four sync edges
    chk("wake", from_reg ? 1 : 5, n);
    chk("hiz after wake", 1'b0, stage_hiz);
    chk("restart ramp", 1'b1, ramp_active);
    n = 0;
    while (ramp_active !== 1'b0 && n < 100) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("restart length", RAMP, n);
  endtask : sleep_cycle

  // Software mode: registers drive settings, straps become the serial lines
  task automatic sw_mode();
    @(posedge ref_clk);
    sw_cfg          <= '{analog_gain: 2'h2, boost: 2'h2, volume: 8'h5a, bridge_mode: 1'b1,
                         rate_mult: 5'h0c, mute: 1'b1, sleep: 1'b0};
    want            <= '{sleep_addr: 1'b1, gain: 2'h3, bridge_clk: 1'b0, rate_data: 1'b1};
    settle();
    exp_cfg = '{analog_gain: 2'h2, boost: 2'h2, volume: 8'h5a, bridge_mode: 1'b1, rate_mult: 5'h0c};
    chk("software_mode", 1'b1, software_mode);
    chk("amp_cfg sw", exp_cfg, amp_cfg);
    chk("i2c_scl", 1'b0, i2c_scl);
    chk("i2c_sda", 1'b1, i2c_sda);
    chk("addr_select", 1'b1, i2c_addr_select);
    chk("mute_5050", 1'b1, mute_5050);
    chk("switching muted", 1'b1, stage_switching);
    @(posedge ref_clk);
    drive_low       <= 1'b1;
    want.bridge_clk <= 1'b1;
    settle();
    chk("sda oe", 1'b1, pin_oe);
    chk("sda out", 1'b0, pin_out);
    chk("i2c_sda low", 1'b0, i2c_sda);
    chk("i2c_scl high", 1'b1, i2c_scl);
    @(posedge ref_clk);
    drive_low       <= 1'b0;
    settle();
    chk("sda released", 1'b0, pin_oe);
    // Mute stays set, so sleep has to override it
    sleep_cycle(1'b1);
    chk("mute after wake", 1'b1, mute_5050);
    @(posedge ref_clk);
    want            <= '{sleep_addr: 1'b0, gain: 2'h0, bridge_clk: 1'b0, rate_data: 1'b0};
    settle();
    chk("back to hw", 1'b0, software_mode);
    chk("mute hw", 1'b0, mute_5050);
    chk("volume hw", VOLUME_0DB, amp_cfg.volume);
  endtask : sw_mode

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    resetn     = 1'b0;
    drive_low  = 1'b0;
    stop_audio = 1'b0;
    want       = '{sleep_addr: 1'b0, gain: 2'h0, bridge_clk: 1'b0, rate_data: 1'b0};
    sw_cfg     = '{analog_gain: 2'h3, boost: 2'h3, volume: 8'h11, bridge_mode: 1'b1,
                   rate_mult: 5'h03, mute: 1'b1, sleep: 1'b1};
    num_errors = 0;
    cmp_count  = 0;
    cycles     = 0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    settle();
    chk("signal path reset", 1'b1, signal_path_enable);
    chk("switching reset", 1'b1, stage_switching);
    hw_decode();
    sleep_cycle(1'b0);
    sw_mode();
    summarize();
  end
endmodule : hw_mode_pin_control_decode_bench
